// [hdl/edp_core.v]
// Extended byte operation datapath with APB register access.
// Assumes an APB master on pclk; data memory lives in edp_mem.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "edp_regs.vh"

// Functional notes
// [RULE1] Operand address spans every memory section directly, no bank select.
// [RULE2] Rotate left into accumulator, bit 7 to bit 0, no flag change.
// [RULE3] Rotate left through carry in memory; only carry changes.
// [RULE4] Rotate left through carry into accumulator; carry from bit 7.
// [RULE5] Rotate right in memory, bit 0 to bit 7, no flag change.
// [RULE6] Rotate right into accumulator; memory and flags untouched.
// [RULE7] Rotate right through carry in memory; only carry changes.
// [RULE8] Rotate right through carry into accumulator; carry from bit 0.
// [RULE9] Subtract with borrow into accumulator, six flags updated.
// [RULE10] Subtract with borrow, same flags, result written to memory.
// [RULE11] Carry cleared on negative result, set on positive or zero.
// [RULE12] Plain subtract, no borrow, same six flags, acc or memory form.
// [RULE13] Decrement, write back or to accumulator, skip on zero.
// [RULE14] Increment, skip on zero, accumulator form leaves memory, no flags.
// [RULE15] A taken skip adds a dummy cycle: three cycles in all.
// [RULE16] Byte set loads FF, bit set forces one bit, no flags.
// [RULE17] Bit test skips when the selected bit is one.
// [RULE18] Byte test rewrites value, skips when nonzero, no flags.
// [RULE19] Byte test rewrites value, skips when zero, no flags.
// [RULE20] Nibble swap in place, no flags.
// [RULE21] Nibble swap into accumulator, memory and flags unchanged.
// [RULE22] Copy byte to accumulator, skip when it is zero.
// [RULE23] Flags not affected by an operation keep their value.
module edp_core #(
  parameter AW = 10
) (
  // Clock, reset, enable
  input wire pclk,
  input wire presetn,
  input wire pce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Datapath state
  output reg [7:0] acc_out,
  output reg [5:0] flags_out,
  output reg busy,
  output reg skip_pulse,
  output reg dummy_cycle
);

  // ************************************
  // Declarations
  // ************************************
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_READ = 2'd1;
  localparam [1:0] S_EXEC = 2'd2;
  localparam [1:0] S_DUMMY = 2'd3;

  reg [1:0] state_q;
  reg [4:0] op_q;
  reg [2:0] bit_q;
  reg [AW-1:0] opadr_q;
  reg [AW-1:0] madr_q;
  reg last_skip_q;
  reg [7:0] res;
  reg [5:0] flg_d;
  reg wr_mem;
  reg wr_acc;
  reg skip;
  reg [8:0] dif9;
  reg [4:0] dif5;
  reg bin;
  reg sbc;
  reg ovf;
  wire [7:0] m;
  wire acc_wr;
  wire apb_rd;
  wire apb_done;
  wire apb_err;
  wire [AW-1:0] mem_addr;
  wire mem_we;
  wire [7:0] mem_wdata;
  wire [7:0] mem_rdata;

  // Address decode helper
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ************************************
  // Data memory
  // ************************************
  // Datapath owns the port while busy, software otherwise
  assign mem_addr = busy ? opadr_q : madr_q; // RULE1
  assign mem_we = busy ? (state_q == S_EXEC) & wr_mem : apb_done & pwrite &
    hit(paddr, `EDP_MDT_OFS) & ~apb_err;
  assign mem_wdata = busy ? res : pwdata[7:0];
  assign m = mem_rdata;

  edp_mem #(
    .AW(AW),
    .DW(8)
  ) u_mem (
    .clk(pclk),
    .ce(pce),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  // ************************************
  // Operation decode and arithmetic
  // ************************************
  // Result, destination, skip and flag updates for the current opcode
  always @*
  begin
    res = m;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    skip = 1'b0;
    flg_d = flags_out; // RULE23
    sbc = (op_q == `EDP_OP_SBC) | (op_q == `EDP_OP_SBCM);
    bin = sbc & ~flags_out[`EDP_F_C];
    dif9 = {1'b0, acc_out} - {1'b0, m} - {8'h00, bin};
    dif5 = {1'b0, acc_out[3:0]} - {1'b0, m[3:0]} - {4'h0, bin};
    ovf = (acc_out[7] ^ m[7]) & (dif9[7] ^ acc_out[7]);
    case (op_q)
      `EDP_OP_RLA:
      begin
        res = {m[6:0], m[7]}; // RULE2
        wr_acc = 1'b1;
      end
      `EDP_OP_RLC, `EDP_OP_RLCA:
      begin
        res = {m[6:0], flags_out[`EDP_F_C]}; // RULE3 RULE4
        flg_d[`EDP_F_C] = m[7];
        wr_mem = (op_q == `EDP_OP_RLC);
        wr_acc = ~wr_mem;
      end
      `EDP_OP_RR:
      begin
        res = {m[0], m[7:1]}; // RULE5
        wr_mem = 1'b1;
      end
      `EDP_OP_RRA:
      begin
        res = {m[0], m[7:1]}; // RULE6
        wr_acc = 1'b1;
      end
      `EDP_OP_RRC, `EDP_OP_RRCA:
      begin
        res = {flags_out[`EDP_F_C], m[7:1]}; // RULE7 RULE8
        flg_d[`EDP_F_C] = m[0];
        wr_mem = (op_q == `EDP_OP_RRC);
        wr_acc = ~wr_mem;
      end
      `EDP_OP_SBC, `EDP_OP_SBCM, `EDP_OP_SUB, `EDP_OP_SUBM:
      begin
        res = dif9[7:0]; // RULE9 RULE12
        wr_acc = (op_q == `EDP_OP_SBC) | (op_q == `EDP_OP_SUB);
        wr_mem = ~wr_acc; // RULE10
        flg_d[`EDP_F_C] = ~dif9[8]; // RULE11
        flg_d[`EDP_F_NIB] = ~dif5[4];
        flg_d[`EDP_F_SRNG] = ovf;
        flg_d[`EDP_F_SRIP] = ovf ^ dif9[7];
        flg_d[`EDP_F_Z] = (dif9[7:0] == 8'h00);
        // Multibyte zero chains through the borrow forms
        flg_d[`EDP_F_MBZ] = (dif9[7:0] == 8'h00) &
          (~sbc | flags_out[`EDP_F_MBZ]);
      end
      `EDP_OP_SDZ, `EDP_OP_SDZA:
      begin
        res = m - 8'h01; // RULE13
        wr_mem = (op_q == `EDP_OP_SDZ);
        wr_acc = ~wr_mem;
        skip = (res == 8'h00);
      end
      `EDP_OP_SIZ, `EDP_OP_SIZA:
      begin
        res = m + 8'h01; // RULE14
        wr_mem = (op_q == `EDP_OP_SIZ);
        wr_acc = ~wr_mem;
        skip = (res == 8'h00);
      end
      `EDP_OP_SET:
      begin
        res = 8'hFF; // RULE16
        wr_mem = 1'b1;
      end
      `EDP_OP_SETB:
      begin
        res = m | (8'h01 << bit_q); // RULE16
        wr_mem = 1'b1;
      end
      `EDP_OP_SNZB:
        skip = m[bit_q]; // RULE17
      `EDP_OP_SNZ:
      begin
        wr_mem = 1'b1; // RULE18
        skip = (m != 8'h00);
      end
      `EDP_OP_SZ:
      begin
        wr_mem = 1'b1; // RULE19
        skip = (m == 8'h00);
      end
      `EDP_OP_SWAP, `EDP_OP_SWAPA:
      begin
        res = {m[3:0], m[7:4]}; // RULE20 RULE21
        wr_mem = (op_q == `EDP_OP_SWAP);
        wr_acc = ~wr_mem;
      end
      `EDP_OP_SZA:
      begin
        wr_acc = 1'b1; // RULE22
        skip = (m == 8'h00);
      end
      default: res = m;
    endcase
  end

  // ************************************
  // APB decode
  // ************************************
  assign apb_rd = psel & penable & ~pready;
  assign apb_done = psel & penable & pready;
  // Refuse a command or memory access while an operation runs
  assign apb_err = (busy & (hit(paddr, `EDP_CMD_OFS) |
    hit(paddr, `EDP_MDT_OFS))) | ~(hit(paddr, `EDP_CMD_OFS) |
    hit(paddr, `EDP_ACC_OFS) | hit(paddr, `EDP_FLG_OFS) |
    hit(paddr, `EDP_STA_OFS) | hit(paddr, `EDP_MAD_OFS) |
    hit(paddr, `EDP_MDT_OFS));
  assign acc_wr = apb_done & pwrite & ~apb_err & hit(paddr, `EDP_ACC_OFS);

  // Answer one cycle into the access phase, read data from a register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (pce)
    begin
      pready <= apb_rd;
      pslverr <= apb_rd & apb_err;
      prdata <= 32'h00000000;
      if (apb_rd & ~pwrite & ~apb_err)
      begin
        if (hit(paddr, `EDP_CMD_OFS))
          prdata <= {{(24-AW){1'b0}}, opadr_q, bit_q, op_q};
        else if (hit(paddr, `EDP_ACC_OFS))
          prdata <= {24'h000000, acc_out};
        else if (hit(paddr, `EDP_FLG_OFS))
          prdata <= {26'h0000000, flags_out};
        else if (hit(paddr, `EDP_STA_OFS))
          prdata <= {29'h00000000, dummy_cycle, last_skip_q, busy};
        else if (hit(paddr, `EDP_MAD_OFS))
          prdata <= {{(32-AW){1'b0}}, madr_q};
        else
          prdata <= {24'h000000, mem_rdata};
      end
    end
  end

  // ************************************
  // Sequencer
  // ************************************
  // Read operand, execute, then a dummy cycle when a skip is taken
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      busy <= 1'b0;
      op_q <= 5'h00;
      bit_q <= 3'h0;
      opadr_q <= {AW{1'b0}};
      madr_q <= {AW{1'b0}};
      skip_pulse <= 1'b0;
      dummy_cycle <= 1'b0;
      last_skip_q <= 1'b0;
    end
    else if (pce)
    begin
      skip_pulse <= 1'b0;
      if (apb_done & pwrite & ~apb_err & hit(paddr, `EDP_MAD_OFS))
        madr_q <= pwdata[AW-1:0];
      case (state_q)
        S_IDLE:
        begin
          if (apb_done & pwrite & ~apb_err & hit(paddr, `EDP_CMD_OFS))
          begin
            op_q <= pwdata[`EDP_CMD_OP_MSB:`EDP_CMD_OP_LSB];
            bit_q <= pwdata[`EDP_CMD_BIT_MSB:`EDP_CMD_BIT_LSB];
            opadr_q <= pwdata[`EDP_CMD_ADR_LSB+AW-1:`EDP_CMD_ADR_LSB]; // RULE1
            busy <= 1'b1;
            state_q <= S_READ;
          end
        end
        S_READ:
          state_q <= S_EXEC;
        S_EXEC:
        begin
          last_skip_q <= skip;
          if (skip)
          begin
            skip_pulse <= 1'b1;
            dummy_cycle <= 1'b1; // RULE15
            state_q <= S_DUMMY;
          end
          else
          begin
            busy <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          dummy_cycle <= 1'b0;
          busy <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ************************************
  // Accumulator and flags
  // ************************************
  // Execution writes win; software may load both while idle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_out <= `EDP_ACC_RST;
      flags_out <= `EDP_FLG_RST;
    end
    else if (pce)
    begin
      if (state_q == S_EXEC)
      begin
        if (wr_acc)
          acc_out <= res;
        flags_out <= flg_d; // RULE23
      end
      else
      begin
        if (acc_wr)
          acc_out <= pwdata[7:0];
        if (apb_done & pwrite & ~apb_err & hit(paddr, `EDP_FLG_OFS))
          flags_out <= pwdata[5:0];
      end
    end
  end

endmodule // edp_core

// [hdl/edp_mem.v]
// Data memory of the datapath: one port, registered read data.
// Assumes the caller holds the address stable for a cycle before using data.
`timescale 1ns/1ps
module edp_mem #(
  parameter AW = 10,
  parameter DW = 8
) (
  // Clock and enable
  input wire clk,
  input wire ce,
  // Access port
  input wire [AW-1:0] addr,
  input wire we,
  input wire [DW-1:0] wdata,
  output reg [DW-1:0] rdata_q
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Write and registered read, frozen while ce is low
  always @(posedge clk)
  begin
    if (ce)
    begin
      if (we)
        mem[addr] <= wdata;
      rdata_q <= mem[addr];
    end
  end

endmodule // edp_mem

// [hdl/edp_regs.vh]
// Constants of the extended byte operation datapath: offsets, fields, codes.
// Assumes byte addresses on an APB bus with 32-bit data.
`ifndef EDP_REGS_VH
`define EDP_REGS_VH

// ************************************
// Register byte offsets
// ************************************
`define EDP_CMD_OFS 8'h00
`define EDP_ACC_OFS 8'h04
`define EDP_FLG_OFS 8'h08
`define EDP_STA_OFS 8'h0C
`define EDP_MAD_OFS 8'h10
`define EDP_MDT_OFS 8'h14

// ************************************
// Command word fields
// ************************************
`define EDP_CMD_OP_LSB 0
`define EDP_CMD_OP_MSB 4
`define EDP_CMD_BIT_LSB 5
`define EDP_CMD_BIT_MSB 7
`define EDP_CMD_ADR_LSB 8

// ************************************
// Status flag positions and reset values
// ************************************
`define EDP_F_C 0
`define EDP_F_Z 1
`define EDP_F_NIB 2
`define EDP_F_SRNG 3
`define EDP_F_SRIP 4
`define EDP_F_MBZ 5
`define EDP_FLG_RST 6'h00
`define EDP_ACC_RST 8'h00

// ************************************
// Operation codes
// ************************************
`define EDP_OP_RLA 5'h00
`define EDP_OP_RLC 5'h01
`define EDP_OP_RLCA 5'h02
`define EDP_OP_RR 5'h03
`define EDP_OP_RRA 5'h04
`define EDP_OP_RRC 5'h05
`define EDP_OP_RRCA 5'h06
`define EDP_OP_SBC 5'h07
`define EDP_OP_SBCM 5'h08
`define EDP_OP_SDZ 5'h09
`define EDP_OP_SDZA 5'h0A
`define EDP_OP_SET 5'h0B
`define EDP_OP_SETB 5'h0C
`define EDP_OP_SIZ 5'h0D
`define EDP_OP_SIZA 5'h0E
`define EDP_OP_SNZB 5'h0F
`define EDP_OP_SNZ 5'h10
`define EDP_OP_SUB 5'h11
`define EDP_OP_SUBM 5'h12
`define EDP_OP_SWAP 5'h13
`define EDP_OP_SWAPA 5'h14
`define EDP_OP_SZ 5'h15
`define EDP_OP_SZA 5'h16

`endif

// [tb/edp_apb_host.sv]
// APB master model standing for the software side of the datapath.
// Assumes one clock; the bench calls its transfer task.
`timescale 1ns/1ps
module edp_apb_host (
  // Clock
  input wire pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // ************************************
  // Transfers
  // ************************************
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never gets an answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~ad; // Released lines stop showing old values
    pwdata <= ~wd;
  endtask
endmodule // edp_apb_host

// [tb/edp_chk_monitor.sv]
// Checker of the datapath's bus answer and execution timing.
// Assumes it is bound to edp_core and sees only that module's ports.
`timescale 1ns/1ps
`include "edp_regs.vh"
module edp_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Datapath state
  input wire [7:0] acc_out,
  input wire [5:0] flags_out,
  input wire busy,
  input wire skip_pulse,
  input wire dummy_cycle
);
  // ************************************
  // Properties
  // ************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Execution steps
  sequence s_exec;
    busy [*2];
  endsequence
  sequence s_skip;
    skip_pulse && dummy_cycle ##1 !busy;
  endsequence
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer malformed");
  a_busy_steps: assert property ($rose(busy) |-> s_exec ##1 (!busy || skip_pulse))
    else $error("operation length wrong");
  a_skip_end: assert property (skip_pulse |-> s_skip)
    else $error("dummy cycle not ending the operation");
  a_skip_dummy: assert property (skip_pulse |-> dummy_cycle && busy && $past(busy, 2))
    else $error("skip without dummy cycle");
  a_idle_quiet: assert property (!busy |-> !skip_pulse && !dummy_cycle)
    else $error("skip while idle");
  a_cmd_start: assert property (
    pready && !pslverr && pwrite && paddr == `EDP_CMD_OFS |=> busy)
    else $error("command did not start");
  a_state_hold: assert property (
    $changed({acc_out, flags_out}) |-> $past(busy) || $past(pready && pwrite))
    else $error("state changed with no cause");
endmodule // edp_chk

// [tb/extended_ops_datapath_tb.sv]
// Self-checking bench of the extended byte operation datapath.
// Assumes edp_core with its memory inside, driven over APB.
`timescale 1ns/1ps
`include "edp_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module extended_ops_datapath_tb;
  // ************************************
  // Signals and instances
  // ************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic busy, skip_pulse, dummy_cycle, xs;
  logic [7:0] paddr, acc_out, xm, xa;
  logic [31:0] pwdata, prdata;
  logic [5:0] flags_out, xf;
  int err_total, samples_checked;
  logic [7:0] corner [5] = '{8'h00, 8'hFF, 8'h01, 8'h80, 8'h7F};
  edp_core #(.AW(10)) DUT (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_out(acc_out), .flags_out(flags_out),
    .busy(busy), .skip_pulse(skip_pulse), .dummy_cycle(dummy_cycle));
  edp_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Expected result of one operation
  function automatic void model(input logic [4:0] op, input logic [2:0] bt,
    input logic [7:0] m, input logic [7:0] a, input logic [5:0] f);
    logic [8:0] r;
    logic [4:0] n;
    logic b;
    {xm, xa, xf, xs} = {m, a, f, 1'b0};
    b = (op == `EDP_OP_SBC || op == `EDP_OP_SBCM) ? ~f[0] : 1'b0;
    r = {1'b0, a} - {1'b0, m} - b;
    n = {1'b0, a[3:0]} - {1'b0, m[3:0]} - b;
    case (op)
      `EDP_OP_RLA: xa = {m[6:0], m[7]};
      `EDP_OP_RLC: {xf[0], xm} = {m, f[0]};
      `EDP_OP_RLCA: {xf[0], xa} = {m, f[0]};
      `EDP_OP_RR: xm = {m[0], m[7:1]};
      `EDP_OP_RRA: xa = {m[0], m[7:1]};
      `EDP_OP_RRC: {xm, xf[0]} = {f[0], m};
      `EDP_OP_RRCA: {xa, xf[0]} = {f[0], m};
      `EDP_OP_SBC, `EDP_OP_SUB: xa = r[7:0];
      `EDP_OP_SBCM, `EDP_OP_SUBM: xm = r[7:0];
      `EDP_OP_SDZ: {xm, xs} = {m - 8'h01, m == 8'h01};
      `EDP_OP_SDZA: {xa, xs} = {m - 8'h01, m == 8'h01};
      `EDP_OP_SET: xm = 8'hFF;
      `EDP_OP_SETB: xm = m | (8'h01 << bt);
      `EDP_OP_SIZ: {xm, xs} = {m + 8'h01, m == 8'hFF};
      `EDP_OP_SIZA: {xa, xs} = {m + 8'h01, m == 8'hFF};
      `EDP_OP_SNZB: xs = m[bt];
      `EDP_OP_SNZ: xs = (m != 8'h00);
      `EDP_OP_SWAP: xm = {m[3:0], m[7:4]};
      `EDP_OP_SWAPA: xa = {m[3:0], m[7:4]};
      `EDP_OP_SZ: xs = (m == 8'h00);
      `EDP_OP_SZA: {xa, xs} = {m, m == 8'h00};
      default: ;
    endcase
    if (op inside {`EDP_OP_SBC, `EDP_OP_SBCM, `EDP_OP_SUB, `EDP_OP_SUBM})
    begin
      xf[0] = ~r[8];
      xf[1] = (r[7:0] == 8'h00);
      xf[2] = ~n[4];
      xf[3] = (a[7] != m[7]) && (r[7] != a[7]);
      xf[4] = xf[3] ^ r[7];
      xf[5] = xf[1] & (f[5] | ~(op == `EDP_OP_SBC || op == `EDP_OP_SBCM));
    end
  endfunction
  // Register access
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, ad, d, r, e);
    `CHK("write error", 1'b0, e)
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge pclk);
    err_total++;
    final_report;
  end
  // ************************************
  // Tests
  // ************************************
  initial
  begin
    logic [31:0] d;
    logic e;
    logic [9:0] ad;
    logic [2:0] bt;
    logic [7:0] m, a;
    logic [5:0] f;
    int k;
    presetn = 1'b0;
    void'($urandom(32'h437F3EC7));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    host.xfer(1'b0, `EDP_FLG_OFS, 32'h0, d, e);
    `CHK("flags reset", 32'h0, d)
    for (int r = 0; r < 6; r++)
    begin
      for (int o = 0; o < 23; o++)
      begin
        ad = 10'($urandom);
        bt = 3'($urandom);
        m = (r < 5) ? corner[r] : 8'($urandom);
        a = (r < 5) ? corner[(r + o) % 5] : 8'($urandom);
        f = 6'($urandom);
        wr(`EDP_MAD_OFS, 32'(ad));
        wr(`EDP_MDT_OFS, 32'(m));
        wr(`EDP_ACC_OFS, 32'(a));
        wr(`EDP_FLG_OFS, 32'(f));
        wr(`EDP_CMD_OFS, 32'({ad, bt, 5'(o)}));
        k = 0;
        do
          host.xfer(1'b0, `EDP_STA_OFS, 32'h0, d, e);
        while (d[0] !== 1'b0 && ++k < 20);
        `CHK("busy clear", 1'b0, d[0])
        model(5'(o), bt, m, a, f);
        `CHK("skip", xs, d[1])
        host.xfer(1'b0, `EDP_FLG_OFS, 32'h0, d, e);
        `CHK("flags", xf, d[5:0])
        `CHK("acc port", xa, acc_out)
        host.xfer(1'b0, `EDP_MDT_OFS, 32'h0, d, e);
        `CHK("memory", xm, d[7:0])
      end
      $display("test operations round %0d done", r);
    end
    host.xfer(1'b0, 8'h18, 32'h0, d, e);
    `CHK("unmapped", 1'b1, e)
    $display("test unmapped done");
    final_report;
  end
endmodule // extended_ops_datapath_tb
bind edp_core edp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .acc_out(acc_out), .flags_out(flags_out), .busy(busy),
  .skip_pulse(skip_pulse), .dummy_cycle(dummy_cycle));
